// ---- hdl/fabric_pkg.sv ----
// package: fabric sizes, slave map, wait-state timing and decode functions
`default_nettype none
package fabric_pkg;
  // ********************************************************************
  // sizes
  // ********************************************************************
  localparam int NM = 2; // master ports
  localparam int NS = 2; // slave ports
  localparam int MAW = 32; // master byte address width
  localparam int DW = 32; // data width of every port
  localparam int SAW = 16; // widest slave word address port
  localparam int CW = 4; // wait-state counter width
  localparam int BYTE_BITS = 2; // byte address bits inside one word

  // ********************************************************************
  // slave map and timing
  // ********************************************************************
  localparam logic [MAW-1:0] S_BASE [NS] = '{32'h0000_0000, 32'h0001_0000};
  localparam int S_AW [NS] = '{14, 8}; // slave word address widths
  localparam logic [CW-1:0] S_SETUP [NS] = '{4'h0, 4'h1}; // cycles before strobe
  localparam logic [CW-1:0] S_WAIT [NS] = '{4'h0, 4'h2}; // fixed strobe wait cycles
  localparam logic [CW-1:0] S_HOLD [NS] = '{4'h0, 4'h1}; // cycles after strobe
  localparam logic [DW-1:0] RDATA_RST = 32'h0000_0000;
  localparam logic [CW-1:0] CNT_RST = 4'h0;

  // ********************************************************************
  // decode functions
  // ********************************************************************
  // true when a byte address lies in the slave's base range
  function automatic logic addr_hit(input logic [MAW-1:0] a, input int s);
    logic [MAW-1:0] off;
    off = a - S_BASE[s];
    return (a >= S_BASE[s]) && ((off >> (BYTE_BITS + S_AW[s])) == '0);
  endfunction

  // slave-aligned word address, bits above the slave width forced low
  function automatic logic [SAW-1:0] word_addr(input logic [MAW-1:0] a, input int s);
    logic [MAW-1:0] off;
    logic [SAW-1:0] w;
    off = (a - S_BASE[s]) >> BYTE_BITS;
    w = '0;
    for (int i = 0; i < SAW; i++) begin
      w[i] = (i < S_AW[s]) ? off[i] : 1'b0;
    end
    return w;
  endfunction
endpackage
`default_nettype wire

// ---- hdl/port_if.sv ----
// interface: one master controller's view toward the slave side of the fabric
`default_nettype none
interface port_if;
  import fabric_pkg::*;
  logic [NS-1:0] tgt; // one-hot decoded target
  logic active; // transfer owns the target (setup, strobe or hold)
  logic rd_stb;
  logic wr_stb;
  logic [SAW-1:0] saddr; // slave-aligned word address
  modport ctl (output tgt, active, rd_stb, wr_stb, saddr);
  modport fab (input tgt, active, rd_stb, wr_stb, saddr);
endinterface
`default_nettype wire

// ---- hdl/master_port_ctl.sv ----
// module: per-master decoder, read-data multiplexer and wait-state machine
`default_nettype none
module master_port_ctl
  import fabric_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [MAW-1:0] m_addr,
  input wire logic m_read,
  input wire logic m_write,
  output logic [DW-1:0] m_rdata,
  output logic m_waitreq,
  input wire logic [NS-1:0] grant,
  input wire logic [NS-1:0][DW-1:0] s_rdata,
  input wire logic [NS-1:0] s_waitreq,
  port_if.ctl pif
);
  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001, ST_ARB = 6'b000010, ST_SETUP = 6'b000100,
    ST_ACC = 6'b001000, ST_HOLD = 6'b010000, ST_DONE = 6'b100000
  } state_e;

  state_e state_q, state_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic [NS-1:0] hit, tgt_q;
  logic [DW-1:0] rdata_q, mux_rdata;
  logic [CW-1:0] setup_c, wait_c, hold_c;
  logic req, acc_end;

  // ********************************************************************
  // address decode
  // ********************************************************************
  // independent decoder for this master
  always_comb begin
    for (int s = 0; s < NS; s++) begin
      hit[s] = addr_hit(m_addr, s);
    end
  end

  // timing figures and slave address of the held target
  always_comb begin
    setup_c = '0;
    wait_c = '0;
    hold_c = '0;
    mux_rdata = '0;
    pif.saddr = '0;
    for (int s = 0; s < NS; s++) begin
      if (tgt_q[s]) begin
        setup_c = S_SETUP[s];
        wait_c = S_WAIT[s];
        hold_c = S_HOLD[s];
        mux_rdata = s_rdata[s];
        pif.saddr = word_addr(m_addr, s);
      end
    end
  end

  assign req = m_read | m_write;
  assign acc_end = (state_q == ST_ACC) && (cnt_q == '0) && ((s_waitreq & tgt_q) == '0);

  // ********************************************************************
  // wait-state machine
  // ********************************************************************
  // next state and counter
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    case (state_q)
      ST_IDLE: begin
        if (req && hit != '0) begin
          state_d = ST_ARB;
        end else if (req) begin
          state_d = ST_DONE; // unmapped: finish with zero data
        end
      end
      ST_ARB: begin
        if ((grant & tgt_q) != '0) begin
          state_d = (setup_c == '0) ? ST_ACC : ST_SETUP;
          cnt_d = (setup_c == '0) ? wait_c : setup_c - 4'h1;
        end
      end
      ST_SETUP: begin
        if (cnt_q == '0) begin
          state_d = ST_ACC;
          cnt_d = wait_c;
        end else begin
          cnt_d = cnt_q - 4'h1;
        end
      end
      ST_ACC: begin
        if (cnt_q != '0) begin
          cnt_d = cnt_q - 4'h1;
        end else if (acc_end) begin
          state_d = (hold_c == '0) ? ST_DONE : ST_HOLD;
          cnt_d = (hold_c == '0) ? '0 : hold_c - 4'h1;
        end
      end
      ST_HOLD: begin
        if (cnt_q == '0) begin
          state_d = ST_DONE;
        end else begin
          cnt_d = cnt_q - 4'h1;
        end
      end
      ST_DONE: state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  // state registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      cnt_q <= CNT_RST;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end

  // target latched when a transfer starts
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tgt_q <= '0;
    end else if (state_q == ST_IDLE) begin
      tgt_q <= req ? hit : '0;
    end else if (state_q == ST_DONE) begin
      tgt_q <= '0;
    end
  end

  // read data captured at the end of the strobe
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= RDATA_RST;
    end else if (state_q == ST_IDLE) begin
      rdata_q <= RDATA_RST;
    end else if (acc_end && m_read) begin
      rdata_q <= mux_rdata;
    end
  end

  // master and slave-side outputs
  assign m_rdata = rdata_q;
  assign m_waitreq = req && (state_q != ST_DONE);
  assign pif.tgt = tgt_q;
  assign pif.active = state_q inside {ST_SETUP, ST_ACC, ST_HOLD};
  assign pif.rd_stb = (state_q == ST_ACC) && m_read;
  assign pif.wr_stb = (state_q == ST_ACC) && m_write;

  // ********************************************************************
  // assertions
  // ********************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  property p_ungranted_waits;
    (state_q == ST_ARB && (grant & tgt_q) == '0) |-> !pif.active && m_waitreq;
  endproperty
  a_ungranted_waits: assert property (p_ungranted_waits) else $error("master ran ungranted");

  property p_setup_before_strobe;
    $rose(state_q == ST_ACC) && setup_c != '0 |-> $past(state_q == ST_SETUP);
  endproperty
  a_setup_before_strobe: assert property (p_setup_before_strobe) else $error("setup skipped");

  property p_hold_after_strobe;
    (state_q == ST_ACC && acc_end && hold_c == 4'h1) |=> state_q == ST_HOLD ##1 state_q == ST_DONE;
  endproperty
  a_hold_after_strobe: assert property (p_hold_after_strobe) else $error("hold length wrong");

  property p_slave_wait_stalls;
    (state_q == ST_ACC && (s_waitreq & tgt_q) != '0) |=> state_q == ST_ACC;
  endproperty
  a_slave_wait_stalls: assert property (p_slave_wait_stalls) else $error("slave wait ignored");

  property p_unmapped_quiet;
    (state_q == ST_IDLE && req && hit == '0) |=> !pif.active && tgt_q == '0 ##1 !pif.active;
  endproperty
  a_unmapped_quiet: assert property (p_unmapped_quiet) else $error("unmapped selected");

  property p_read_data_muxed;
    (acc_end && m_read) |=> m_rdata == $past(mux_rdata);
  endproperty
  a_read_data_muxed: assert property (p_read_data_muxed) else $error("read data not taken");

  property p_release_once;
    (req && !m_waitreq) |=> state_q == ST_IDLE;
  endproperty
  a_release_once: assert property (p_release_once) else $error("bad release");

  c_slow_read: cover property (state_q == ST_HOLD ##[1:8] state_q == ST_DONE && m_read);
  c_arb_stall: cover property (state_q == ST_ARB [*3]);
  c_unmapped: cover property (state_q == ST_IDLE && req && hit == '0);
endmodule
`default_nettype wire

// ---- hdl/fabric_top.sv ----
// module: interconnect fabric top joining all master ports to all slave ports
`default_nettype none
module fabric_top
  import fabric_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [NM-1:0][MAW-1:0] m_addr,
  input wire logic [NM-1:0] m_read,
  input wire logic [NM-1:0] m_write,
  input wire logic [NM-1:0][DW-1:0] m_wdata,
  output logic [NM-1:0][DW-1:0] m_rdata,
  output logic [NM-1:0] m_waitreq,
  input wire logic [NM-1:0][NS-1:0] arb_grant,
  output logic [NS-1:0] s_sel,
  output logic [NS-1:0][SAW-1:0] s_addr,
  output logic [NS-1:0] s_read,
  output logic [NS-1:0] s_write,
  output logic [NS-1:0][DW-1:0] s_wdata,
  input wire logic [NS-1:0][DW-1:0] s_rdata,
  input wire logic [NS-1:0] s_waitreq
);
  port_if pif [NM] ();
  logic [NM-1:0][NS-1:0] tgt;
  logic [NM-1:0] active, rd_stb, wr_stb;
  logic [NM-1:0][SAW-1:0] saddr;
  logic [NM-1:0][NS-1:0] grant_col;

  // ********************************************************************
  // per-master controllers
  // ********************************************************************
  // one decoder, mux and wait machine per master
  for (genvar m = 0; m < NM; m++) begin : g_m
    master_port_ctl u_ctl (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .m_addr(m_addr[m]),
      .m_read(m_read[m]),
      .m_write(m_write[m]),
      .m_rdata(m_rdata[m]),
      .m_waitreq(m_waitreq[m]),
      .grant(arb_grant[m]),
      .s_rdata(s_rdata),
      .s_waitreq(s_waitreq),
      .pif(pif[m])
    );
    assign tgt[m] = pif[m].tgt;
    assign active[m] = pif[m].active;
    assign rd_stb[m] = pif[m].rd_stb;
    assign wr_stb[m] = pif[m].wr_stb;
    assign saddr[m] = pif[m].saddr;
    assign grant_col[m] = arb_grant[m] & tgt[m];
  end

  // ********************************************************************
  // slave-side drive
  // ********************************************************************
  // each slave follows the granted master that targets it; the arbiter
  // keeps grants one-hot per slave, lowest master wins if it does not
  always_comb begin
    s_sel = '0;
    s_addr = '0;
    s_read = '0;
    s_write = '0;
    s_wdata = '0;
    for (int s = 0; s < NS; s++) begin
      for (int m = NM - 1; m >= 0; m--) begin
        if (grant_col[m][s]) begin
          s_sel[s] = active[m];
          s_addr[s] = saddr[m];
          s_read[s] = rd_stb[m];
          s_write[s] = wr_stb[m];
        end
        // write data reaches every slave the master holds a grant on
        if (arb_grant[m][s]) begin
          s_wdata[s] = m_wdata[m];
        end
      end
    end
  end

  // ********************************************************************
  // assertions
  // ********************************************************************
  property p_sel_needs_request;
    @(posedge ref_clk) disable iff (!rst_n)
    s_sel[0] |-> (m_read | m_write) != '0;
  endproperty
  a_sel_needs_request: assert property (p_sel_needs_request) else $error("select while idle");

  property p_strobe_under_sel;
    @(posedge ref_clk) disable iff (!rst_n)
    (s_read[1] || s_write[1]) |-> s_sel[1] && $past(s_sel[1]) ##1 s_sel[1];
  endproperty
  a_strobe_under_sel: assert property (p_strobe_under_sel) else $error("setup/hold lost");

  property p_wdata_broadcast;
    @(posedge ref_clk) disable iff (!rst_n)
    (arb_grant[0] == 2'b11) |-> s_wdata[0] == m_wdata[0] && s_wdata[1] == m_wdata[0];
  endproperty
  a_wdata_broadcast: assert property (p_wdata_broadcast) else $error("write data altered");

  c_two_masters: cover property (@(posedge ref_clk) s_sel[0] && s_sel[1]);
  c_slave1_write: cover property (@(posedge ref_clk) s_write[1] ##1 s_sel[1] ##1 !s_sel[1]);
endmodule
`default_nettype wire

// ---- test/slave_model.sv ----
// partner: behavioural slave ports with word memory and programmable stall
`default_nettype none
module slave_model
  import fabric_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [NS-1:0] s_sel,
  input wire logic [NS-1:0][SAW-1:0] s_addr,
  input wire logic [NS-1:0] s_read,
  input wire logic [NS-1:0] s_write,
  input wire logic [NS-1:0][DW-1:0] s_wdata,
  input wire logic [NS-1:0][CW-1:0] stall,
  output logic [NS-1:0][DW-1:0] s_rdata,
  output logic [NS-1:0] s_waitreq
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************************
  // slave behaviour
  // ****************************************************************
  logic [DW-1:0] noise_q;
  // changing pattern so an unread slave never shows stale data
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      noise_q <= 32'h5a5a_0f0f;
    end else begin
      noise_q <= ~noise_q + 32'h0000_0001;
    end
  end
  // one port per slave, carrying no interrupt line at all
  for (genvar s = 0; s < NS; s++) begin : g_s
    logic [CW-1:0] cnt_q;
    logic [DW-1:0] mem_q [16];
    logic stb;
    assign stb = s_read[s] | s_write[s];
    assign s_waitreq[s] = stb && (cnt_q < stall[s]); // stall first strobe cycles
    assign s_rdata[s] = s_read[s] ? mem_q[s_addr[s][3:0]] : noise_q;
    // count strobe cycles, saturating at the stall length
    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        cnt_q <= 4'h0;
      end else if (!stb) begin
        cnt_q <= 4'h0;
      end else if (s_waitreq[s]) begin
        cnt_q <= cnt_q + 4'h1;
      end
    end
    // write data taken only under own select
    always_ff @(posedge ref_clk) begin
      if (s_sel[s] && s_write[s] && !s_waitreq[s]) begin
        mem_q[s_addr[s][3:0]] <= s_wdata[s];
      end
    end
  end
endmodule
`default_nettype wire

// ---- test/tb.sv ----
// testbench: fabric top with two master drivers and slave model
`default_nettype none
module tb
  import fabric_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, rst_n;
  logic [NM-1:0][MAW-1:0] m_addr;
  logic [NM-1:0] m_read, m_write, m_waitreq;
  logic [NM-1:0][DW-1:0] m_wdata, m_rdata;
  logic [NM-1:0][NS-1:0] arb_grant;
  logic [NS-1:0] s_sel, s_read, s_write, s_waitreq;
  logic [NS-1:0][SAW-1:0] s_addr;
  logic [NS-1:0][DW-1:0] s_wdata, s_rdata;
  logic [NS-1:0][CW-1:0] stall;
  int fails, checks;
  int n [NM], seln [NM], stbn [NM];
  logic [DW-1:0] rd [NM], sw [NM];
  logic [SAW-1:0] sa [NM];
  fabric_top i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .m_addr(m_addr), .m_read(m_read),
    .m_write(m_write), .m_wdata(m_wdata), .m_rdata(m_rdata), .m_waitreq(m_waitreq),
    .arb_grant(arb_grant), .s_sel(s_sel), .s_addr(s_addr), .s_read(s_read),
    .s_write(s_write), .s_wdata(s_wdata), .s_rdata(s_rdata), .s_waitreq(s_waitreq));
  slave_model i_slave (.ref_clk(ref_clk), .rst_n(rst_n), .s_sel(s_sel), .s_addr(s_addr),
    .s_read(s_read), .s_write(s_write), .s_wdata(s_wdata), .stall(stall),
    .s_rdata(s_rdata), .s_waitreq(s_waitreq));
  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic chk(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    if (fails == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // one master transfer; counts wait, select and strobe cycles of slave s
  task automatic xfer(input int m, input int s, input logic [MAW-1:0] a, input logic wr,
                      input logic [DW-1:0] d);
    @(posedge ref_clk);
    m_addr[m] <= a;
    m_write[m] <= wr;
    m_read[m] <= !wr;
    m_wdata[m] <= d;
    n[m] = 0;
    seln[m] = 0;
    stbn[m] = 0;
    forever begin
      @(negedge ref_clk);
      if (s < NS) begin
        seln[m] += s_sel[s];
        if (s_read[s] | s_write[s]) begin
          stbn[m]++;
          sa[m] = s_addr[s];
          sw[m] = s_wdata[s];
        end
      end else if (s_sel != '0) begin
        seln[m]++;
      end
      if (m_waitreq[m] === 1'b0 || n[m] > 40) break;
      n[m]++;
      @(posedge ref_clk);
    end
    if (m_waitreq[m] !== 1'b0) fails++; // limit ran out
    rd[m] = m_rdata[m];
    @(posedge ref_clk);
    m_read[m] <= 1'b0;
    m_write[m] <= 1'b0;
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_slave0();
    xfer(0, 0, 32'h0000_fffc, 1'b1, 32'ha5a5_0001);
    chk(n[0], 3);
    chk(seln[0], 1);
    chk(stbn[0], 1);
    chk(sa[0], 16'h3fff);
    chk(sw[0], 32'ha5a5_0001);
    @(negedge ref_clk);
    chk(s_wdata[1], 32'ha5a5_0001);
    xfer(0, 0, 32'h0000_fffc, 1'b0, '0);
    chk(rd[0], 32'ha5a5_0001);
  endtask
  task automatic t_slave1();
    xfer(0, 1, 32'h0001_0008, 1'b1, 32'h1234_5678);
    chk(n[0], 7);
    chk(seln[0], 5);
    chk(stbn[0], 3);
    chk(sa[0], 16'h0002);
    stall[1] <= 4'h4;
    xfer(0, 1, 32'h0001_0008, 1'b0, '0);
    chk(n[0], 9);
    chk(seln[0], 7);
    chk(stbn[0], 5);
    chk(rd[0], 32'h1234_5678);
  endtask
  task automatic t_unmapped();
    logic [MAW-1:0] a [2];
    a = '{32'h0002_0000, 32'h0001_0400};
    for (int i = 0; i < 2; i++) begin
      xfer(0, NS, a[i], 1'b0, '0);
      chk(n[0], 1);
      chk(seln[0], 0);
      chk(rd[0], 32'h0000_0000);
    end
  endtask
  task automatic t_grant();
    arb_grant <= '0;
    fork
      xfer(1, 0, 32'h0000_fffc, 1'b0, '0);
      begin
        @(posedge ref_clk);
        repeat (6) begin
          @(negedge ref_clk);
          chk(s_sel[0], 1'b0);
          chk(m_waitreq[1], 1'b1);
        end
        @(posedge ref_clk);
        arb_grant[1] <= 2'b01;
      end
    join
    chk(n[1] > 6, 1);
    chk(rd[1], 32'ha5a5_0001);
  endtask
  task automatic t_dual();
    arb_grant <= {2'b01, 2'b10};
    stall <= '0;
    fork
      xfer(0, 1, 32'h0001_0008, 1'b0, '0);
      xfer(1, 0, 32'h0000_fffc, 1'b0, '0);
    join
    chk(rd[0], 32'h1234_5678);
    chk(rd[1], 32'ha5a5_0001);
    chk(n[0], 7);
    chk(n[1], 3);
  endtask
  // ****************************************************************
  // clock, sequence and watchdog
  // ****************************************************************
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  initial begin
    rst_n = 1'b0;
    m_addr = '0;
    m_read = '0;
    m_write = '0;
    m_wdata = '0;
    arb_grant = {2'b00, 2'b11};
    stall = '0;
    fails = 0;
    checks = 0;
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_slave0();
    t_slave1();
    t_unmapped();
    t_grant();
    t_dual();
    stop_test();
  end
  // run needs well under a thousand cycles
  initial begin
    #20000;
    fails++;
    stop_test();
  end
endmodule
`default_nettype wire
